// ===== src/sesr_top.sv
/*
 eight stage shift register with sign repeat, three state parallel pins,
 a wishbone register port and a capture fifo of stage snapshots.
 assumes every pin input is asynchronous to clk_i and is synchronised
 here; the shift clock arrives as a pin and is edge detected.
*/
`timescale 1ns/1ps
`default_nettype none
module sesr_top
    import sesr_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              pin_clk_i,
    input  wire logic              async_wipe_n_i,
    input  wire logic              stage_enable_n_i,
    input  wire logic              shift_not_load_i,
    input  wire logic              sign_repeat_n_i,
    input  wire logic              serial_source_pick_i,
    input  wire logic              serial_in_zero_i,
    input  wire logic              serial_in_one_i,
    input  wire logic              out_enable_n_i,
    input  wire logic [STAGES-1:0] par_i,
    output logic      [STAGES-1:0] par_o,
    output logic      [STAGES-1:0] par_oe_o,
    output logic                   expansion_out_o
);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("capture depth must be a power of two of at least two");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic              clk_d;
        logic [STAGES-1:0] stage;
        logic [STAGES-1:0] oe;
        logic              pend;
        logic              capture_en;
        logic              overrun;
        logic              ack;
        logic [31:0]       rdata;
    } sesr_state_t;

    sesr_state_t q;
    sesr_state_t n;

    logic [SYNC_W-1:0] raw;
    logic [STAGES-1:0] pins;
    logic              wipe;
    logic              load_mode;
    logic              shift_mode;
    logic              sign_keep;
    logic              clk_rise;
    logic              hit;
    logic              wr_ctrl;
    logic              wr_status;
    logic              rd_capture;
    logic              step_wr;
    logic              req;
    logic              want;
    logic              cap_stall;
    logic              go;
    logic              serial_bit;
    logic              first_bit;
    logic [STAGES-1:0] calc;
    logic [31:0]       rd_word;

    sesr_fifo_if #(.W(STAGES)) cap_if ();

    sesr_fifo #(
        .WIDTH (STAGES),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .f     (cap_if.store)
    );

    // ----------------------------------------
    // pin bundle and decoded modes
    // ----------------------------------------
    assign raw = {pin_clk_i, out_enable_n_i, async_wipe_n_i, stage_enable_n_i,
                  shift_not_load_i, sign_repeat_n_i, serial_source_pick_i,
                  serial_in_zero_i, serial_in_one_i, par_i};

    assign pins       = q.s2[B_PAR +: STAGES];
    assign wipe       = ~q.s2[B_WIPE_N];
    assign load_mode  = ~q.s2[B_EN_N] & ~q.s2[B_SHIFT];
    assign shift_mode = ~q.s2[B_EN_N] &  q.s2[B_SHIFT];
    assign sign_keep  = ~q.s2[B_SIGN_N];
    assign clk_rise   = q.s2[B_CLK] & ~q.clk_d;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign hit        = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr_ctrl    = hit & wb_we_i & (wb_adr_i == ADR_CTRL) & wb_sel_i[0];
    assign wr_status  = hit & wb_we_i & (wb_adr_i == ADR_STATUS) & wb_sel_i[1];
    assign rd_capture = hit & ~wb_we_i & (wb_adr_i == ADR_CAPTURE);
    assign step_wr    = wr_ctrl & wb_dat_i[CTRL_STEP];

    // ----------------------------------------
    // step scheduling and capture stall
    // ----------------------------------------
    assign req       = clk_rise | step_wr;
    assign want      = (req | q.pend) & ~wipe;
    assign cap_stall = q.capture_en & ~cap_if.push_ready;
    assign go        = want & ~cap_stall;

    assign cap_if.push_valid = want & q.capture_en;
    assign cap_if.push_data  = calc;
    assign cap_if.pop_ready  = rd_capture;

    // ----------------------------------------
    // stage next value
    // ----------------------------------------
    assign serial_bit = q.s2[B_PICK] ? q.s2[B_D1] : q.s2[B_D0];
    assign first_bit  = sign_keep ? q.stage[SIGN_STAGE] : serial_bit;

    // oe is not an input of the next stage value
    always_comb begin
        if (q.s2[B_EN_N]) begin
            calc = q.stage;
        end else if (!q.s2[B_SHIFT]) begin
            calc = pins;
        end else begin
            calc = {q.stage[STAGES-2:0], first_bit};
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            ADR_CTRL: begin
                rd_word[CTRL_CAPTURE] = q.capture_en;
            end
            ADR_STATUS: begin
                rd_word[STAGES-1:0] = q.stage;
                rd_word[ST_EXP]     = q.stage[LAST_STAGE];
                rd_word[ST_NEMPTY]  = cap_if.pop_valid;
                rd_word[ST_FULL]    = ~cap_if.push_ready;
                rd_word[ST_OVERRUN] = q.overrun;
            end
            ADR_CAPTURE: begin
                if (cap_if.pop_valid) begin
                    rd_word[STAGES-1:0] = cap_if.pop_data;
                end
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = q;
        n.s1    = raw;
        n.s2    = q.s1;
        n.clk_d = q.s2[B_CLK];
        if (wipe) begin
            n.stage = RST_STAGE;
            n.pend  = 1'b0;
        end else if (go) begin
            n.stage = calc;
            n.pend  = 1'b0;
        end else begin
            n.pend  = want & cap_stall;
        end
        n.oe = {STAGES{~q.s2[B_OE_N] & ~load_mode}};
        if (wr_ctrl) begin
            n.capture_en = wb_dat_i[CTRL_CAPTURE];
        end
        if (wr_status && wb_dat_i[ST_OVERRUN]) begin
            n.overrun = 1'b0;
        end
        if (q.pend && req && cap_stall && !wipe) begin
            n.overrun = 1'b1;
        end
        n.ack   = hit;
        n.rdata = hit ? rd_word : 32'h0000_0000;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q            <= '0;
            q.stage      <= RST_STAGE;
            q.capture_en <= RST_CAPTURE;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign par_o           = q.stage;
    assign par_oe_o        = q.oe;
    assign expansion_out_o = q.stage[LAST_STAGE];
    assign wb_ack_o        = q.ack;
    assign wb_dat_o        = q.rdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_wipe_clears: assert property (
        wipe |=> (q.stage == 8'h00))
        else $error("stages not cleared by wipe");

    a_edge_only: assert property (
        !go && !wipe |=> $stable(q.stage))
        else $error("stages changed without a step");

    a_hold_keeps: assert property (
        go && q.s2[B_EN_N] |=> $stable(q.stage))
        else $error("hold step altered stages");

    a_shift_moves: assert property (
        go && shift_mode |=> (q.stage[7:1] == $past(q.stage[6:0])))
        else $error("shift did not move stages");

    a_serial_pick: assert property (
        go && shift_mode && !sign_keep |=> (q.stage[0] == $past(serial_bit)))
        else $error("first stage missed the picked serial input");

    a_sign_keeps: assert property (
        go && shift_mode && sign_keep |=> $stable(q.stage[0]))
        else $error("sign stage not repeated");

    a_load_copies: assert property (
        go && load_mode |=> (q.stage == $past(pins)))
        else $error("load did not copy pins");

    a_load_floats: assert property (
        load_mode |=> (par_oe_o == 8'h00))
        else $error("pins driven in load mode");

    a_oe_floats: assert property (
        q.s2[B_OE_N] |=> (par_oe_o == 8'h00))
        else $error("pins driven with output enable high");

    a_pins_drive: assert property (
        !q.s2[B_OE_N] && !load_mode |=> (par_oe_o == 8'hff))
        else $error("pins not driven when enabled");

    a_wipe_load_z: assert property (
        wipe && load_mode |=> (par_oe_o == 8'h00) && (q.stage == 8'h00))
        else $error("wipe in load mode drove pins or kept data");

    a_expansion_follows: assert property (
        go && shift_mode |=> (expansion_out_o == $past(q.stage[6])))
        else $error("expansion output did not follow last stage");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");

    a_ack_timely: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given in the next cycle");

    a_overrun_sets: assert property (
        q.pend && req && cap_stall && !wipe |=> q.overrun)
        else $error("lost step did not set overrun");

    // ----------------------------------------
    // bus and capture checks
    // ----------------------------------------

    a_ack_needs_req: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");

    a_dat_idle: assert property (
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data not zero outside ack");

    a_ctrl_write: assert property (
        wr_ctrl |=> (q.capture_en == $past(wb_dat_i[CTRL_CAPTURE])))
        else $error("capture enable not written");

    a_pend_waits: assert property (
        q.pend && cap_stall && !wipe |=> q.pend && $stable(q.stage))
        else $error("pending step moved stages");

    a_pend_resumes: assert property (
        q.pend && !cap_stall && !wipe |-> go)
        else $error("pending step not resumed");

    a_wipe_cancels: assert property (
        wipe |=> !q.pend)
        else $error("wipe left a step pending");

    a_overrun_clears: assert property (
        wr_status && wb_dat_i[ST_OVERRUN] && !(q.pend && req && cap_stall && !wipe)
        |=> !q.overrun)
        else $error("overrun not cleared");

    a_overrun_sticks: assert property (
        q.overrun && !(wr_status && wb_dat_i[ST_OVERRUN]) |=> q.overrun)
        else $error("overrun dropped without a clear");

    a_capture_grows: assert property (
        go && q.capture_en |=> cap_if.pop_valid)
        else $error("captured step not stored");

    a_rise_steps: assert property (
        clk_rise && !wipe && !q.capture_en |-> go)
        else $error("pin clock rise did not step");

    a_wipe_drives: assert property (
        wipe && !q.s2[B_OE_N] && !load_mode |=> (par_oe_o == 8'hff))
        else $error("wipe floated enabled pins");

    c_overrun_hit: cover property (q.pend && req && cap_stall && !wipe);
    c_load_step: cover property (go && load_mode);
    c_sign_step: cover property (go && shift_mode && sign_keep);
    c_capture_stall: cover property (want && cap_stall);
    c_capture_pop: cover property (rd_capture && cap_if.pop_valid);
endmodule
`default_nettype wire

// ===== src/sesr_pkg.sv
/*
 package of the sign extending shift register: stage layout, register
 offsets, field positions, reset values and pin bundle positions.
 assumes a 25 MHz system clock and a classic wishbone slave port.
*/
// Behaviour
// - clear low wipes all stages, ignoring others
// - stages change only on clock rising edge; the code also steps on a control register write with the step bit set
// - enable high keeps all stages unchanged
// - shift mode moves each stage one place
// - first stage takes picked serial input
// - sign repeat keeps first stage value
// - load mode copies the eight pin levels
// - load mode releases the eight pins
// - output enable high floats pins only
// - output enable never alters next state
// - clear during load mode keeps pins floating
// - expansion output always follows last stage
package sesr_pkg;
    // ----------------------------------------
    // stage layout and clock
    // ----------------------------------------
    localparam int          STAGES        = 8;
    localparam int          SIGN_STAGE    = 0;
    localparam int          LAST_STAGE    = 7;
    localparam int          CLK_HZ        = 25_000_000;
    localparam int          FIFO_DEPTH    = 16;
    localparam logic [7:0]  RST_STAGE     = 8'h00;
    localparam logic        RST_CAPTURE   = 1'b0;
    // ----------------------------------------
    // register offsets and fields
    // ----------------------------------------
    localparam logic [3:0]  ADR_CTRL      = 4'h0;
    localparam logic [3:0]  ADR_STATUS    = 4'h4;
    localparam logic [3:0]  ADR_CAPTURE   = 4'h8;
    localparam int          CTRL_CAPTURE  = 0;
    localparam int          CTRL_STEP     = 1;
    localparam int          ST_EXP        = 8;
    localparam int          ST_NEMPTY     = 9;
    localparam int          ST_FULL       = 10;
    localparam int          ST_OVERRUN    = 11;
    // ----------------------------------------
    // synchronised pin bundle positions
    // ----------------------------------------
    localparam int          B_PAR         = 0;
    localparam int          B_D1          = 8;
    localparam int          B_D0          = 9;
    localparam int          B_PICK        = 10;
    localparam int          B_SIGN_N      = 11;
    localparam int          B_SHIFT       = 12;
    localparam int          B_EN_N        = 13;
    localparam int          B_WIPE_N      = 14;
    localparam int          B_OE_N        = 15;
    localparam int          B_CLK         = 16;
    localparam int          SYNC_W        = 17;
endpackage

// ===== src/sesr_fifo_if.sv
/*
 carrier between the shift register core and its capture fifo.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface sesr_fifo_if #(parameter int W = 8);
    logic           push_valid;
    logic           push_ready;
    logic [W-1:0]   push_data;
    logic           pop_valid;
    logic           pop_ready;
    logic [W-1:0]   pop_data;
    modport client (output push_valid, output push_data, input push_ready,
                    input pop_valid, input pop_data, output pop_ready);
    modport store  (input push_valid, input push_data, output push_ready,
                    output pop_valid, output pop_data, input pop_ready);
endinterface
`default_nettype wire

// ===== src/sesr_fifo.sv
/*
 capture fifo: width and depth parameters, valid and ready both sides.
 assumes synchronous active high reset; depth a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module sesr_fifo
    import sesr_pkg::*;
#(
    parameter int WIDTH = STAGES,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    sesr_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("fifo depth must be a power of two of at least two");
    end
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } sesr_fifo_state_t;
    sesr_fifo_state_t q;
    sesr_fifo_state_t n;
    logic full;
    logic empty;
    assign full  = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign empty = (q.wp == q.rp);
    assign f.push_ready = ~full;
    assign f.pop_valid  = ~empty;
    assign f.pop_data   = q.mem[q.rp[AW-1:0]];
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = q;
        if (f.push_valid && !full) begin
            n.mem[q.wp[AW-1:0]] = f.push_data;
            n.wp = q.wp + (AW+1)'(1);
        end
        if (f.pop_ready && !empty) begin
            n.rp = q.rp + (AW+1)'(1);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_fifo_no_overfill: assert property (@(posedge clk_i) disable iff (rst_i)
        full && !(f.pop_ready && !empty) |=> full && $stable(q.wp))
        else $error("fifo write pointer moved while full");
    a_fifo_no_underrun: assert property (@(posedge clk_i) disable iff (rst_i)
        empty |=> $stable(q.rp))
        else $error("fifo read pointer moved while empty");
endmodule
`default_nettype wire

// ===== tb/sesr_pin_partner.sv
/*
 far side bus logic sharing the eight parallel pins with the device.
 assumes the device enables its drivers through one enable per pin.
*/
`timescale 1ns/1ps
`default_nettype none
module sesr_pin_partner
    import sesr_pkg::*;
(
    input  wire logic [STAGES-1:0] dev_par_i,
    input  wire logic [STAGES-1:0] dev_oe_i,
    input  wire logic [STAGES-1:0] load_val_i,
    output logic      [STAGES-1:0] wire_o
);
    // ----------------------------------------
    // wire level from both parties
    // ----------------------------------------
    // far side lets go of each line the device drives
    assign wire_o = (dev_oe_i & dev_par_i)
                  | (~dev_oe_i & load_val_i);
endmodule
`default_nettype wire

// ===== tb/tb.sv
/*
 self checking bench of the sign extending shift register.
 assumes the pin partner model and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin comparisons++; if ((got) !== (want)) begin miscompares++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module tb
    import sesr_pkg::*;
;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pin_clk_i;
    logic async_wipe_n_i, stage_enable_n_i, shift_not_load_i, sign_repeat_n_i;
    logic serial_source_pick_i, serial_in_zero_i, serial_in_one_i, out_enable_n_i;
    logic expansion_out_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] par_i, par_o, par_oe_o, load_val, exp;
    int miscompares = 0;
    int comparisons = 0;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    sesr_top #(.DEPTH(4)) sesr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_clk_i(pin_clk_i),
        .async_wipe_n_i(async_wipe_n_i), .stage_enable_n_i(stage_enable_n_i),
        .shift_not_load_i(shift_not_load_i), .sign_repeat_n_i(sign_repeat_n_i),
        .serial_source_pick_i(serial_source_pick_i), .serial_in_zero_i(serial_in_zero_i),
        .serial_in_one_i(serial_in_one_i), .out_enable_n_i(out_enable_n_i), .par_i(par_i),
        .par_o(par_o), .par_oe_o(par_oe_o), .expansion_out_o(expansion_out_o));
    sesr_pin_partner sesr_pin_partner_inst (.dev_par_i(par_o), .dev_oe_i(par_oe_o),
        .load_val_i(load_val), .wire_o(par_i));
    // ----------------------------------------
    // clock, verdict and bus tasks
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic conclude;
        if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= adr; wb_sel_i <= 4'h3; wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (n >= 20) begin
            miscompares++;
            conclude();
        end
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pins(input logic en_n, sl, sn, pick, d0, d1, input logic [7:0] ld);
        stage_enable_n_i <= en_n; shift_not_load_i <= sl; sign_repeat_n_i <= sn;
        serial_source_pick_i <= pick; serial_in_zero_i <= d0; serial_in_one_i <= d1;
        load_val <= ld;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic step(input logic en_n, sl, sn, pick, d0, d1, input logic [7:0] ld);
        pins(en_n, sl, sn, pick, d0, d1, ld);
        `CHK(par_o, exp)
        `CHK(par_oe_o, {8{~out_enable_n_i & (en_n | sl)}})
        if (!en_n) exp = sl ? {exp[6:0], sn ? (pick ? d1 : d0) : exp[0]} : ld;
        pin_clk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        pin_clk_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(par_o, exp)
        `CHK(expansion_out_o, exp[7])
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_modes;
        step(0, 0, 1, 0, 0, 0, 8'h96);
        step(0, 1, 1, 0, 1, 0, 8'h00);
        step(0, 1, 1, 1, 1, 0, 8'hff);
        step(0, 1, 1, 0, 0, 1, 8'h00);
        step(0, 1, 1, 1, 0, 1, 8'h00);
        step(0, 1, 0, 0, 0, 0, 8'h00);
        step(0, 1, 0, 1, 1, 1, 8'h00);
        step(1, 1, 1, 0, 1, 1, 8'h00);
        step(1, 0, 1, 0, 1, 1, 8'h3c);
    endtask
    task automatic t_oe;
        out_enable_n_i <= 1'b1;
        step(0, 1, 1, 0, 1, 0, 8'h00);
        step(0, 0, 1, 0, 0, 0, 8'h5a);
        out_enable_n_i <= 1'b0;
        step(0, 1, 0, 0, 0, 0, 8'h00);
    endtask
    task automatic t_wipe;
        pins(0, 0, 1, 0, 0, 0, 8'hc3);
        async_wipe_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        exp = 8'h00;
        `CHK(par_o, exp)
        `CHK(par_oe_o, 8'h00)
        async_wipe_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_fifo;
        logic [31:0] q;
        logic [7:0] que[$];
        int i;
        pins(0, 1, 1, 0, 1, 0, 8'h00);
        wb(1'b1, ADR_CTRL, 32'h1, q);
        for (i = 0; i < 6; i++) begin
            wb(1'b1, ADR_CTRL, 32'h3, q);
            if (i < 4) begin
                exp = {exp[6:0], 1'b1};
                que.push_back(exp);
            end
            repeat (3) @(posedge clk_i);
        end
        wb(1'b0, ADR_STATUS, 32'h0, q);
        `CHK(q, {20'h0, 1'b1, 1'b1, 1'b1, exp[7], exp})
        exp = {exp[6:0], 1'b1};
        que.push_back(exp);
        for (i = 0; i < 5; i++) begin
            wb(1'b0, ADR_CAPTURE, 32'h0, q);
            `CHK(q, {24'h0, que[i]})
        end
        wb(1'b0, ADR_CAPTURE, 32'h0, q);
        `CHK(q, 32'h0)
        wb(1'b1, ADR_STATUS, 32'h800, q);
        wb(1'b0, ADR_STATUS, 32'h0, q);
        `CHK(q, {23'h0, exp[7], exp})
        wb(1'b0, 4'hc, 32'h0, q);
        `CHK(q, 32'h0)
        wb(1'b1, ADR_CTRL, 32'h0, q);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = 4'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0; pin_clk_i = 1'b0;
        async_wipe_n_i = 1'b1; stage_enable_n_i = 1'b1; shift_not_load_i = 1'b1;
        sign_repeat_n_i = 1'b1; serial_source_pick_i = 1'b0; serial_in_zero_i = 1'b0;
        serial_in_one_i = 1'b0; out_enable_n_i = 1'b0; load_val = 8'h00; exp = 8'h00;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(par_o, 8'h00)
        t_modes();
        t_oe();
        t_wipe();
        t_fifo();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
